// ---- verilog/line_coding_pkg.sv ----
// shared types, code groups and constants for the 100 Mb/s line coding block
package line_coding_pkg;
  localparam logic [4:0]  SYM_I       = 5'h1f;
  localparam logic [4:0]  SYM_J       = 5'h18;
  localparam logic [4:0]  SYM_K       = 5'h11;
  localparam logic [4:0]  SYM_T       = 5'h0d;
  localparam logic [4:0]  SYM_R       = 5'h07;
  localparam logic [4:0]  SYM_H       = 5'h04;
  localparam logic [3:0]  PREAMBLE    = 4'h5;
  localparam logic [2:0]  SYM_LAST    = 3'h4;
  localparam logic [2:0]  PRE2_AT     = 3'h2;
  localparam logic [5:0]  LOCK_LEN    = 6'h20;
  localparam logic [10:0] SCR_RESET   = 11'h7ff;
  localparam logic [5:0]  SEED_LOW    = 6'h3f;
  localparam logic [1:0]  MLT_ZERO_A  = 2'h0;

  typedef enum {TX_IDLE, TX_K, TX_DATA, TX_R} txState_e;
  typedef enum {RX_HUNT, RX_RECV, RX_WAITR} rxState_e;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] data;
  } txMii_s;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] data;
  } rxMii_s;

  typedef struct packed {
    logic invalidSym;
    logic haltSeen;
    logic prematureEnd;
  } status_s;

  function automatic logic [4:0] encodeNibble(input logic [3:0] n);
    logic [4:0] s;
    s = SYM_I;
    case (n)
      4'h0: s = 5'h1e;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0a;
      4'h5: s = 5'h0b;
      4'h6: s = 5'h0e;
      4'h7: s = 5'h0f;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'ha: s = 5'h16;
      4'hb: s = 5'h17;
      4'hc: s = 5'h1a;
      4'hd: s = 5'h1b;
      4'he: s = 5'h1c;
      default: s = 5'h1d;
    endcase
    return s;
  endfunction : encodeNibble

  // returns {isData, nibble}; isData low for control and invalid groups
  function automatic logic [4:0] decodeSymbol(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (encodeNibble(4'(i)) == s) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : decodeSymbol

  function automatic logic isControl(input logic [4:0] s);
    return (s == SYM_I) || (s == SYM_J) || (s == SYM_K) || (s == SYM_T) ||
           (s == SYM_R) || (s == SYM_H);
  endfunction : isControl
endpackage : line_coding_pkg

// ---- verilog/fast_ethernet_line_coding.sv ----
// 4b/5b coding, scrambling, nrzi and mlt-3 line stage with polarity correction
// Behaviour
// - nibbles coded to 5-bit groups and back
// - 16 data, 6 control, 10 invalid groups
// - halt for error, idle, J/K, T/R delimiters
// - invalid received group sets invalid flag
// - received halt sets halt flag
// - invalid groups sent only when enabled with error, or as raw groups in symbol mode
// - scramble transmit, descramble receive at 100M
// - transmit scrambler seeded from phy address
// - symbol mode bypasses scrambler and descrambler
// - transmit nrzi mapped to three levels
// - received three levels mapped back to nrzi
// - speed selects manchester or mlt-3 output
// - swapped receive polarity corrected automatically at 10M or during autoneg
// - J/K replace preamble, T/R after enable drops
// - J/K replaced by two preamble nibbles, aligns
// - nrzi encode transmit, nrzi decode receive
`timescale 1ns/1ps
`default_nettype none
module fast_ethernet_line_coding (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire line_coding_pkg::txMii_s txMii,
  output logic                         txNibbleReq,
  input  wire logic [4:0]              txSymbol,
  input  wire logic                    symbolMode,
  input  wire logic                    txInvalidEn,
  input  wire logic                    speed10,
  input  wire logic                    autoNegActive,
  input  wire logic                    man10Data,
  input  wire logic [4:0]              phyAddr,
  input  wire logic                    statusClear,
  output line_coding_pkg::rxMii_s      rxMii,
  output logic [4:0]                   rxSymbol,
  output line_coding_pkg::status_s     detailed_status_reg,
  output logic                         polarityInverted,
  output logic                         line_tx_pos,
  output logic                         line_tx_neg,
  input  wire logic                    line_rx_pos,
  input  wire logic                    line_rx_neg
);
  import line_coding_pkg::*;

  // ---------------- transmit ----------------
  txState_e    txState_reg, txState_next;
  logic [2:0]  txCnt_reg, txCnt_next;
  logic [4:0]  txShift_reg, txShift_next;
  logic [10:0] txScr_reg, txScr_next;
  logic        seeded_reg, seeded_next;
  logic        txNrzi_reg, txNrzi_next;
  logic [1:0]  txMlt_reg, txMlt_next;
  logic        txPos_reg, txPos_next;
  logic        txNeg_reg, txNeg_next;
  logic        manPhase_reg, manPhase_next;
  logic [4:0]  addrSync1_reg, addrSync2_reg;
  logic        txKey, txBit, symLoad;
  logic [4:0]  txSym;

  assign symLoad     = (txCnt_reg == SYM_LAST);
  assign txNibbleReq = symLoad;
  assign txKey       = txScr_reg[10] ^ txScr_reg[8];
  assign txBit       = symbolMode ? txShift_reg[4] : txShift_reg[4] ^ txKey;

  always_comb begin
    txState_next = txState_reg;
    txSym        = SYM_I;
    if (symbolMode) begin
      txSym        = txSymbol;
      txState_next = TX_IDLE;
    end else begin
      case (txState_reg)
        TX_IDLE: begin
          if (txMii.en) begin
            txSym        = SYM_J;
            txState_next = TX_K;
          end
        end
        TX_K: begin
          txSym        = SYM_K;
          txState_next = TX_DATA;
        end
        TX_DATA: begin
          if (!txMii.en) begin
            txSym        = SYM_T;
            txState_next = TX_R;
          end else if (txMii.er) begin
            // only half the raw low groups are outside the table, giving a test pattern
            txSym = txInvalidEn ? {1'b0, txMii.data} : SYM_H;
          end else begin
            txSym = encodeNibble(txMii.data);
          end
        end
        TX_R: begin
          txSym        = SYM_R;
          txState_next = TX_IDLE;
        end
        default: txState_next = TX_IDLE;
      endcase
    end
  end

  always_comb begin
    txCnt_next    = symLoad ? 3'h0 : txCnt_reg + 3'h1;
    txShift_next  = symLoad ? txSym : {txShift_reg[3:0], 1'b0};
    seeded_next   = 1'b1;
    txScr_next    = seeded_reg ? {txScr_reg[9:0], txKey} : {addrSync2_reg, SEED_LOW};
    txNrzi_next   = txNrzi_reg ^ txBit;
    txMlt_next    = txNrzi_reg ? txMlt_reg + 2'h1 : txMlt_reg;
    manPhase_next = ~manPhase_reg;
    if (speed10) begin
      txPos_next = manPhase_reg ? ~man10Data : man10Data;
      txNeg_next = ~txPos_next;
    end else begin
      txPos_next = (txMlt_reg == 2'h1);
      txNeg_next = (txMlt_reg == 2'h3);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txState_reg   <= TX_IDLE;
      txCnt_reg     <= 3'h0;
      txShift_reg   <= SYM_I;
      txScr_reg     <= SCR_RESET;
      seeded_reg    <= 1'b0;
      txNrzi_reg    <= 1'b0;
      txMlt_reg     <= MLT_ZERO_A;
      txPos_reg     <= 1'b0;
      txNeg_reg     <= 1'b0;
      manPhase_reg  <= 1'b0;
    end else begin
      txState_reg   <= symLoad ? txState_next : txState_reg;
      txCnt_reg     <= txCnt_next;
      txShift_reg   <= txShift_next;
      txScr_reg     <= txScr_next;
      seeded_reg    <= seeded_next;
      txNrzi_reg    <= txNrzi_next;
      txMlt_reg     <= txMlt_next;
      txPos_reg     <= txPos_next;
      txNeg_reg     <= txNeg_next;
      manPhase_reg  <= manPhase_next;
    end
  end

  // no reset: the strap is captured while nrst is low, so the seed sees it at release
  always_ff @(posedge clk) begin
    addrSync1_reg <= phyAddr;
    addrSync2_reg <= addrSync1_reg;
  end

  assign line_tx_pos = txPos_reg;
  assign line_tx_neg = txNeg_reg;

  // ---------------- receive ----------------
  logic [1:0]  rxSync1_reg, rxSync2_reg;
  logic        polInv_reg, polInv_next;
  logic        lineIdle_reg, lineIdle_next;
  logic [1:0]  rxLvl_reg, rxLvl_next;
  logic        rxNrzi_reg, rxNrzi_next;
  logic [10:0] rxScr_reg, rxScr_next;
  logic [5:0]  lockCnt_reg, lockCnt_next;
  logic [9:0]  rxWin_reg, rxWin_next;
  logic [2:0]  rxCnt_reg, rxCnt_next;
  logic        prePend_reg, prePend_next;
  rxState_e    rxState_reg, rxState_next;
  rxMii_s      rxMii_reg, rxMii_next;
  logic [4:0]  rxSym_reg, rxSym_next;
  status_s     stat_reg, stat_next;
  logic [1:0]  lvl;
  logic        nrziBit, nrzBit, rxKey, locked, plain;
  logic [4:0]  curSym, dec;

  // swapping the pair swaps which wire carries the positive pulse
  assign lvl     = polInv_reg ? {rxSync2_reg[0], rxSync2_reg[1]} : rxSync2_reg;
  assign nrziBit = (lvl != rxLvl_reg);
  assign nrzBit  = nrziBit ^ rxNrzi_reg;
  assign rxKey   = rxScr_reg[10] ^ rxScr_reg[8];
  assign locked  = (lockCnt_reg == LOCK_LEN);
  assign plain   = symbolMode ? nrzBit : nrzBit ^ rxKey;
  assign curSym  = {rxWin_reg[3:0], plain};
  assign dec     = decodeSymbol(curSym);

  always_comb begin
    polInv_next   = polInv_reg;
    lineIdle_next = (rxSync2_reg == 2'b00);
    // a pulse out of silence is a link pulse, positive when wired right
    if ((speed10 || autoNegActive) && lineIdle_reg && (rxSync2_reg != 2'b00) &&
        (rxSync2_reg != 2'b11)) begin
      polInv_next = rxSync2_reg[0];
    end
    rxLvl_next  = lvl;
    rxNrzi_next = nrziBit;
    // idle is all ones in clear, so unlocked the key is the inverted line
    rxScr_next  = {rxScr_reg[9:0], locked ? rxKey : ~nrzBit};
    if (locked) begin
      lockCnt_next = lockCnt_reg;
    end else if (~nrzBit == rxKey) begin
      lockCnt_next = lockCnt_reg + 6'h01;
    end else begin
      lockCnt_next = 6'h00;
    end
    rxWin_next   = {rxWin_reg[8:0], plain};
    rxCnt_next   = (rxCnt_reg == SYM_LAST) ? 3'h0 : rxCnt_reg + 3'h1;
    rxState_next = rxState_reg;
    prePend_next = prePend_reg;
    rxMii_next   = '0;
    rxSym_next   = rxSym_reg;
    stat_next    = stat_reg;
    if (statusClear) begin
      stat_next = '0;
    end
    case (rxState_reg)
      RX_HUNT: begin
        if ({rxWin_reg[8:0], plain} == {SYM_J, SYM_K}) begin
          rxMii_next   = '{dv: 1'b1, er: 1'b0, data: PREAMBLE};
          prePend_next = 1'b1;
          rxCnt_next   = 3'h0;
          rxState_next = RX_RECV;
        end
      end
      RX_RECV: begin
        if (prePend_reg && rxCnt_reg == PRE2_AT) begin
          rxMii_next   = '{dv: 1'b1, er: 1'b0, data: PREAMBLE};
          prePend_next = 1'b0;
        end
        if (rxCnt_reg == SYM_LAST) begin
          rxSym_next = curSym;
          if (dec[4]) begin
            rxMii_next = '{dv: 1'b1, er: 1'b0, data: dec[3:0]};
          end else if (curSym == SYM_T) begin
            rxState_next = RX_WAITR;
          end else if (curSym == SYM_I) begin
            rxMii_next             = '{dv: 1'b0, er: 1'b1, data: 4'h0};
            stat_next.prematureEnd = 1'b1;
            rxState_next           = RX_HUNT;
          end else if (curSym == SYM_H) begin
            rxMii_next         = '{dv: 1'b1, er: 1'b1, data: 4'h0};
            stat_next.haltSeen = 1'b1;
          end else if (isControl(curSym)) begin
            rxMii_next = '{dv: 1'b1, er: 1'b1, data: 4'h0};
          end else begin
            rxMii_next           = '{dv: 1'b1, er: 1'b1, data: 4'h0};
            stat_next.invalidSym = 1'b1;
          end
        end
      end
      RX_WAITR: begin
        if (rxCnt_reg == SYM_LAST) begin
          rxState_next = RX_HUNT;
        end
      end
      default: rxState_next = RX_HUNT;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxSync1_reg  <= 2'b00;
      rxSync2_reg  <= 2'b00;
      polInv_reg   <= 1'b0;
      lineIdle_reg <= 1'b1;
      rxLvl_reg    <= 2'b00;
      rxNrzi_reg   <= 1'b0;
      rxScr_reg    <= SCR_RESET;
      lockCnt_reg  <= 6'h00;
      rxWin_reg    <= 10'h3ff;
      rxCnt_reg    <= 3'h0;
      prePend_reg  <= 1'b0;
      rxState_reg  <= RX_HUNT;
      rxMii_reg    <= '0;
      rxSym_reg    <= SYM_I;
      stat_reg     <= '0;
    end else begin
      rxSync1_reg  <= {line_rx_pos, line_rx_neg};
      rxSync2_reg  <= rxSync1_reg;
      polInv_reg   <= polInv_next;
      lineIdle_reg <= lineIdle_next;
      rxLvl_reg    <= rxLvl_next;
      rxNrzi_reg   <= rxNrzi_next;
      rxScr_reg    <= rxScr_next;
      lockCnt_reg  <= lockCnt_next;
      rxWin_reg    <= rxWin_next;
      rxCnt_reg    <= rxCnt_next;
      prePend_reg  <= prePend_next;
      rxState_reg  <= rxState_next;
      rxMii_reg    <= rxMii_next;
      rxSym_reg    <= rxSym_next;
      stat_reg     <= stat_next;
    end
  end

  assign rxMii               = rxMii_reg;
  assign rxSymbol            = rxSym_reg;
  assign detailed_status_reg = stat_reg;
  assign polarityInverted    = polInv_reg;

  // ---------------- checks ----------------
  a_mlt_no_both: assert property (@(posedge clk) disable iff (!nrst) !(line_tx_pos && line_tx_neg))
    else $error("both line outputs high");
  a_mlt_hold_zero: assert property (@(posedge clk) disable iff (!nrst)
    !txNrzi_reg |=> txMlt_reg == $past(txMlt_reg)) else $error("mlt moved on zero");
  a_nibble_period: assert property (@(posedge clk) disable iff (!nrst)
    txNibbleReq |=> !txNibbleReq [*4] ##1 txNibbleReq) else $error("nibble period wrong");
  a_jk_start: assert property (@(posedge clk) disable iff (!nrst)
    symLoad && !symbolMode && txState_reg == TX_IDLE && txMii.en |=> txShift_reg == SYM_J
    ##5 txShift_reg == SYM_K) else $error("no J/K at frame start");
  a_halt_on_err: assert property (@(posedge clk) disable iff (!nrst)
    symLoad && !symbolMode && txState_reg == TX_DATA && txMii.en && txMii.er && !txInvalidEn
    |=> txShift_reg == SYM_H) else $error("error not sent as halt");
  a_invalid_flag: assert property (@(posedge clk) disable iff (!nrst)
    rxState_reg == RX_RECV && rxCnt_reg == SYM_LAST && !dec[4] && !isControl(curSym)
    |=> detailed_status_reg.invalidSym) else $error("invalid flag not set");
  a_halt_flag: assert property (@(posedge clk) disable iff (!nrst)
    rxState_reg == RX_RECV && rxCnt_reg == SYM_LAST && curSym == SYM_H
    |=> detailed_status_reg.haltSeen && rxMii.er) else $error("halt flag not set");
  a_pre_after_jk: assert property (@(posedge clk) disable iff (!nrst)
    rxState_reg == RX_HUNT && rxState_next == RX_RECV
    |=> rxMii.dv && rxMii.data == PREAMBLE ##3 rxMii.dv && rxMii.data == PREAMBLE)
    else $error("preamble not substituted");
  a_scr_bypass: assert property (@(posedge clk) disable iff (!nrst)
    symbolMode |=> txNrzi_reg == ($past(txNrzi_reg) ^ $past(txShift_reg[4])))
    else $error("scrambler not bypassed");
  a_seed_addr: assert property (@(posedge clk) disable iff (!nrst)
    !seeded_reg |=> txScr_reg == {$past(addrSync2_reg), SEED_LOW}) else $error("bad seed");
  c_frame_tx: cover property (@(posedge clk) disable iff (!nrst) txState_reg == TX_R);
  c_frame_rx: cover property (@(posedge clk) disable iff (!nrst) rxState_reg == RX_WAITR);
  c_pol_swap: cover property (@(posedge clk) disable iff (!nrst) $rose(polInv_reg));
  c_desc_lock: cover property (@(posedge clk) disable iff (!nrst) $rose(locked));
endmodule : fast_ethernet_line_coding
`default_nettype wire

// ---- testbench/mac_model.sv ----
// behavioural mac: drives nibbles or raw groups on request, collects received nibbles
`timescale 1ns/1ps
`default_nettype none
module mac_model (
  input  wire logic                    clk,
  input  wire logic                    txNibbleReq,
  output var  line_coding_pkg::txMii_s txMii,
  output var  logic [4:0]              txSymbol,
  input  wire line_coding_pkg::rxMii_s rxMii
);
  import line_coding_pkg::*;
  logic [4:0] rxQ[$];

  initial begin
    txMii = '0;
    txSymbol = SYM_I;
  end

  // items are {er,nibble} in mii mode and raw groups in symbol mode
  task automatic send(input logic [4:0] q[$], input logic sym);
    int n;
    foreach (q[i]) begin
      n = 0;
      @(negedge clk);
      while (txNibbleReq !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      if (sym) begin
        txSymbol = q[i];
      end else begin
        txMii = '{en: 1'b1, er: q[i][4], data: q[i][3:0]};
      end
      @(posedge clk);
    end
    // the next request edge is five cycles away, so dropping here is safe
    @(negedge clk);
    txMii = '0;
    txSymbol = SYM_I;
  endtask : send

  // sampled mid-cycle, clear of the edge that launches the pulse
  always @(negedge clk) begin
    if (rxMii.dv === 1'b1) begin
      rxQ.push_back({rxMii.er, rxMii.data});
    end
  end
endmodule : mac_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// line coding testbench: line looped back, frames sent and received through the mac model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import line_coding_pkg::*;
  logic       clk, nrst, symbolMode, txInvalidEn, speed10, autoNegActive;
  logic       man10Data, statusClear, txNibbleReq, polarityInverted;
  logic       txPos, txNeg, rxPos, rxNeg, loopOn, drvP, drvN;
  logic [4:0] phyAddr, txSymbol, rxSymbol;
  logic [1:0] lastLvl, prevLvl;
  txMii_s     txMii;
  rxMii_s     rxMii;
  status_s    stat;
  int         n_errors = 0;
  int         checks_done = 0;

  assign rxPos = loopOn ? txPos : drvP;
  assign rxNeg = loopOn ? txNeg : drvN;

  fast_ethernet_line_coding i_dut (.clk(clk), .nrst(nrst), .txMii(txMii),
    .txNibbleReq(txNibbleReq), .txSymbol(txSymbol), .symbolMode(symbolMode),
    .txInvalidEn(txInvalidEn), .speed10(speed10), .autoNegActive(autoNegActive),
    .man10Data(man10Data), .phyAddr(phyAddr), .statusClear(statusClear), .rxMii(rxMii),
    .rxSymbol(rxSymbol), .detailed_status_reg(stat), .polarityInverted(polarityInverted),
    .line_tx_pos(txPos), .line_tx_neg(txNeg), .line_rx_pos(rxPos), .line_rx_neg(rxNeg));

  mac_model i_mac (.clk(clk), .txNibbleReq(txNibbleReq), .txMii(txMii),
    .txSymbol(txSymbol), .rxMii(rxMii));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic checkBit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : checkBit

  task automatic checkNib(input logic [4:0] got, input logic [4:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : checkNib

  // errored entries carry no defined nibble, so only their er bit is compared
  task automatic checkRx(input logic [4:0] exp[$]);
    checkBit(i_mac.rxQ.size() == exp.size(), 1'b1, "rx nibble count");
    foreach (exp[i]) begin
      if (i < i_mac.rxQ.size()) begin
        checkNib(exp[i][4] ? {i_mac.rxQ[i][4], 4'h0} : i_mac.rxQ[i], exp[i], "rx nibble");
      end
    end
    i_mac.rxQ.delete();
  endtask : checkRx

  // mlt-3 watch: zero between levels, levels alternate, first step goes positive
  always @(negedge clk) begin
    if (nrst && !speed10 && loopOn && {txPos, txNeg} != prevLvl) begin
      checkBit({txPos, txNeg} != 2'b11 && ({txPos, txNeg} == 2'b00 ? prevLvl != 2'b00 :
               (prevLvl == 2'b00 && {txPos, txNeg} != lastLvl)), 1'b1, "mlt-3 step");
      if ({txPos, txNeg} != 2'b00) begin
        lastLvl = {txPos, txNeg};
      end
      prevLvl = {txPos, txNeg};
    end
  end

  task automatic doReset(input logic [4:0] addr, input logic sym, output logic [79:0] tr);
    nrst = 1'b0;
    phyAddr = addr;
    symbolMode = sym;
    lastLvl = 2'b01;
    prevLvl = 2'b00;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      tr = {tr[77:0], txPos, txNeg};
    end
    // idle long enough for the descrambler to lock
    repeat (300) @(negedge clk);
    statusClear = 1'b1;
    @(negedge clk);
    statusClear = 1'b0;
    i_mac.rxQ.delete();
  endtask : doReset

  task automatic test_done;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    logic [4:0]  fr[$];
    logic [79:0] tr1, tr2;
    nrst = 1'b0;
    symbolMode = 1'b0;
    txInvalidEn = 1'b0;
    speed10 = 1'b0;
    autoNegActive = 1'b0;
    man10Data = 1'b0;
    statusClear = 1'b0;
    phyAddr = 5'h00;
    loopOn = 1'b1;
    drvP = 1'b0;
    drvN = 1'b0;
    doReset(5'h01, 1'b0, tr1);
    doReset(5'h02, 1'b0, tr2);
    checkBit(tr1 != tr2, 1'b1, "scrambler seed follows address");
    fr = {5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h0d};
    for (int i = 0; i < 16; i++) begin
      fr.push_back(5'(i));
    end
    i_mac.send(fr, 1'b0);
    repeat (100) @(negedge clk);
    checkRx(fr);
    checkBit(stat.prematureEnd, 1'b0, "end delimiter seen");
    checkBit(stat.invalidSym, 1'b0, "data groups valid");
    for (int k = 1; k >= 0; k--) begin
      txInvalidEn = k[0];
      i_mac.send({5'h05, 5'h05, 5'h05, 5'h0d, 5'h01, 5'h12, 5'h03}, 1'b0);
      repeat (100) @(negedge clk);
      checkRx({5'h05, 5'h05, 5'h05, 5'h0d, 5'h01, 5'h10, 5'h03});
      checkBit(stat.invalidSym, k[0], "forced invalid code");
      checkBit(stat.haltSeen, !k[0], "error sent as halt");
      statusClear = 1'b1;
      @(negedge clk);
      statusClear = 1'b0;
    end
    doReset(5'h01, 1'b1, tr1);
    i_mac.send({SYM_J, SYM_K, 5'h15, SYM_H, 5'h0b, 5'h01, SYM_T, SYM_R}, 1'b1);
    repeat (100) @(negedge clk);
    checkRx({5'h05, 5'h05, 5'h03, 5'h10, 5'h05, 5'h10});
    checkBit(stat.haltSeen, 1'b1, "halt flag");
    checkBit(stat.invalidSym, 1'b1, "invalid flag");
    checkNib(rxSymbol, SYM_T, "last framed group");
    speed10 = 1'b1;
    man10Data = 1'b1;
    loopOn = 1'b0;
    doReset(5'h00, 1'b0, tr1);
    // restart the history so the first compare is against the previous half period
    @(negedge clk);
    tr1 = {tr1[77:0], txPos, txNeg};
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      checkBit(txPos ^ txNeg, 1'b1, "manchester two-level");
      checkBit(txPos != tr1[1], 1'b1, "manchester half period");
      tr1 = {tr1[77:0], txPos, txNeg};
    end
    // neg-only pulse at 100M is ignored, swaps under autoneg, pos-only at 10M restores
    for (int k = 0; k < 3; k++) begin
      speed10 = (k == 2);
      autoNegActive = (k == 1);
      repeat (20) @(negedge clk);
      drvN = (k < 2);
      drvP = (k == 2);
      repeat (3) @(negedge clk);
      drvN = 1'b0;
      drvP = 1'b0;
      repeat (20) @(negedge clk);
      checkBit(polarityInverted, k == 1, "polarity correction");
    end
    test_done();
  end
endmodule : testbench
`default_nettype wire
